// ---- src/trig_pacer.sv ----
// Measure trigger selection, pacer and auxiliary trigger port
// Contract
// - Aux or GP-port source triggers only on the selected edge direction.
// - Rising code means low-to-high, falling code means high-to-low.
// - Edge select resets to rising; defaults command leaves it alone.
// - Internal source: pacer spaces successive triggers by the sample period.
// - Period spans zero to 2^32-1 quarter microseconds.
// - Periods up to ten microseconds become exactly ten microseconds.
// - Defaults load one millisecond, or six for megohm functions.
// - Autoscan off: new revisions gap passes by period, old by ten microseconds.
// - Port drive on makes aux port zero an output, off an input.
// - Port drive and aux-zero source selection exclude each other.
// - Output mode re-emits each measure trigger as a low pulse.
// - GP-port source takes triggers from the general-purpose port.
// - Triggers ignored during scan delay and ten microseconds after each start.
// - Source choices hold/single/system/internal/aux/GP; internal at reset.
`timescale 1ns/1ps
module trig_pacer
  import trig_pacer_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Trigger inputs
  input wire logic i_aux_zero,
  input wire logic i_aux_one,
  input wire logic i_gp_port,
  input wire logic i_sys_trig,
  input wire logic i_scan_accept,
  input wire logic i_scan_delay_done,
  input wire logic i_pass_end,
  // Trigger outputs
  output logic o_meas_trig,
  output logic o_pass_gap_done,
  output logic o_aux_zero_out,
  output logic o_aux_zero_oe
);

  src_t source;
  logic edge_sel;
  logic [31:0] sample_period;
  logic port_drive_out;
  logic autoscan;
  logic new_rev;
  logic megohm;
  logic [2:0] scan_source;
  logic [2:0] stop_source;
  logic [2:0] sync0;
  logic [2:0] sync1;
  logic [2:0] prev;
  logic [31:0] eff_period;
  logic [31:0] pace_cnt;
  logic [$clog2(QUANTUM_CYCLES+1)-1:0] q_cnt;
  logic tick;
  logic [7:0] hold_cnt;
  logic scan_block;
  logic single_req;
  logic raw_trig;
  logic ext_edge;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [1:0] pulse_cnt;
  logic gap_active;
  logic [31:0] gap_cnt;

  wire wr_src = i_wr && i_addr == ADDR_SOURCE;
  wire wr_port = i_wr && i_addr == ADDR_PORT;
  wire wr_cmd = i_wr && i_addr == ADDR_CMD;
  wire wr_scan = i_wr && i_addr == ADDR_SCAN;
  wire defaults = wr_cmd && i_wdata[CMD_DEFAULTS_BIT];
  wire aux0_used = source == SRC_AUX_ZERO || scan_source == 3'h4 || stop_source == 3'h4;
  wire [2:0] new_scan = i_wdata[SCAN_SRC_LSB +: 3];
  wire [2:0] new_stop = i_wdata[STOP_SRC_LSB +: 3];

  // Source selector, power-on internal
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      source <= SRC_INTERNAL;
    end else if (wr_src && i_wdata[2:0] <= 3'h6) begin
      if (!(port_drive_out && i_wdata[2:0] == 3'h4)) begin
        source <= src_t'(i_wdata[2:0]);
      end
    end else if (defaults) begin
      source <= SRC_INTERNAL;
    end
  end

  // Scan and stop source copies, aux zero refused while driving
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scan_source <= 3'h0;
      stop_source <= 3'h0;
    end else if (wr_scan) begin
      if (!(port_drive_out && new_scan == 3'h4)) begin
        scan_source <= new_scan;
      end
      if (!(port_drive_out && new_stop == 3'h4)) begin
        stop_source <= new_stop;
      end
    end
  end

  // Edge select, untouched by defaults
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      edge_sel <= rising_edge_code;
    end else if (i_wr && i_addr == ADDR_EDGE) begin
      edge_sel <= i_wdata[0];
    end
  end

  // Sample period in quarter microseconds
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_period <= RESET_PERIOD_Q;
    end else if (defaults) begin
      sample_period <= megohm ? MEGOHM_PERIOD_Q : DEFAULT_PERIOD_Q;
    end else if (i_wr && i_addr == ADDR_PERIOD) begin
      sample_period <= i_wdata;
    end
  end

  // Port and mode bits
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      port_drive_out <= 1'b0;
      autoscan <= 1'b0;
      new_rev <= 1'b1;
      megohm <= 1'b0;
    end else if (wr_port) begin
      if (!(i_wdata[PORT_DRIVE_BIT] && aux0_used)) begin
        port_drive_out <= i_wdata[PORT_DRIVE_BIT];
      end
      autoscan <= i_wdata[AUTOSCAN_BIT];
      new_rev <= i_wdata[NEW_REV_BIT];
      megohm <= i_wdata[MEGOHM_BIT];
    end else if (defaults) begin
      autoscan <= 1'b0;
    end
  end

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync0 <= 3'h0;
      sync1 <= 3'h0;
      prev <= 3'h0;
    end else begin
      sync0 <= {i_gp_port, i_aux_one, i_aux_zero};
      sync1 <= sync0;
      prev <= sync1;
    end
  end

  // Edge detection per input
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_edge
      assign rise[g] = sync1[g] && !prev[g];
      assign fall[g] = !sync1[g] && prev[g];
    end
  endgenerate

  // External edge for the selected source
  always_comb begin
    ext_edge = 1'b0;
    case (source)
      SRC_AUX_ZERO: ext_edge = !port_drive_out &&
        (edge_sel == rising_edge_code ? rise[0] : fall[0]);
      SRC_AUX_ONE: ext_edge = edge_sel == rising_edge_code ? rise[1] : fall[1];
      SRC_GP_PORT: ext_edge = edge_sel == rising_edge_code ? rise[2] : fall[2];
      default: ext_edge = 1'b0;
    endcase
  end

  // Quantum tick every QUANTUM_CYCLES, 3 cycles (0.3 us) at 10 MHz
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_cnt <= '0;
    end else if (q_cnt == ($bits(q_cnt))'(QUANTUM_CYCLES - 1)) begin
      q_cnt <= '0;
    end else begin
      q_cnt <= q_cnt + 1'b1;
    end
  end
  assign tick = q_cnt == ($bits(q_cnt))'(QUANTUM_CYCLES - 1);

  // Periods at or below ten microseconds become ten microseconds
  assign eff_period = (sample_period <= MIN_PERIOD_Q) ? MIN_PERIOD_Q : sample_period;

  // Single command request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      single_req <= 1'b0;
    end else if (wr_cmd && i_wdata[CMD_SINGLE_BIT] && source == SRC_SINGLE) begin
      single_req <= 1'b1;
    end else if (o_meas_trig) begin
      single_req <= 1'b0;
    end
  end

  // Raw trigger before the hold-off gate
  always_comb begin
    raw_trig = 1'b0;
    case (source)
      SRC_SINGLE: raw_trig = single_req;
      SRC_SYSTEM: raw_trig = i_sys_trig;
      SRC_INTERNAL: raw_trig = pace_cnt == 32'h0;
      default: raw_trig = ext_edge;
    endcase
  end

  // Scan delay window blocks triggers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scan_block <= 1'b0;
    end else if (i_scan_accept) begin
      scan_block <= 1'b1;
    end else if (i_scan_delay_done) begin
      scan_block <= 1'b0;
    end
  end

  // Ten microsecond hold-off after each measurement start
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_cnt <= 8'h0;
    end else if (o_meas_trig) begin
      hold_cnt <= 8'(HOLDOFF_CYCLES - 1);
    end else if (hold_cnt != 8'h0) begin
      hold_cnt <= hold_cnt - 8'h1;
    end
  end

  assign o_meas_trig = raw_trig && !scan_block && hold_cnt == 8'h0 && source != SRC_HOLD;

  // Pacer down-counter reloaded at each trigger
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pace_cnt <= MIN_PERIOD_Q;
    end else if (o_meas_trig || source != SRC_INTERNAL) begin
      pace_cnt <= eff_period;
    end else if (tick && pace_cnt != 32'h0) begin
      pace_cnt <= pace_cnt - 32'h1;
    end
  end

  // Gap between scan passes with autoscan off
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_active <= 1'b0;
      gap_cnt <= 32'h0;
      o_pass_gap_done <= 1'b0;
    end else begin
      o_pass_gap_done <= 1'b0;
      if (i_pass_end && !autoscan) begin
        gap_active <= 1'b1;
        gap_cnt <= (new_rev ? eff_period : MIN_PERIOD_Q) - 32'h1;
      end else if (gap_active && tick) begin
        if (gap_cnt == 32'h0) begin
          gap_active <= 1'b0;
          o_pass_gap_done <= 1'b1;
        end else begin
          gap_cnt <= gap_cnt - 32'h1;
        end
      end
    end
  end

  // Negative pulse on aux port zero for each measure trigger
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_cnt <= 2'h0;
    end else if (o_meas_trig && port_drive_out) begin
      pulse_cnt <= 2'(PULSE_CYCLES);
    end else if (pulse_cnt != 2'h0) begin
      pulse_cnt <= pulse_cnt - 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_aux_zero_out <= 1'b1;
      o_aux_zero_oe <= 1'b0;
    end else begin
      o_aux_zero_oe <= port_drive_out;
      o_aux_zero_out <= !(o_meas_trig && port_drive_out) && pulse_cnt <= 2'h1;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      if (i_addr == ADDR_SOURCE) begin
        o_rdata <= {29'h0, source};
      end else if (i_addr == ADDR_EDGE) begin
        o_rdata <= {31'h0, edge_sel};
      end else if (i_addr == ADDR_PERIOD) begin
        o_rdata <= sample_period;
      end else if (i_addr == ADDR_PORT) begin
        o_rdata <= {28'h0, megohm, new_rev, autoscan, port_drive_out};
      end else if (i_addr == ADDR_STATUS) begin
        o_rdata <= {22'h0, hold_cnt != 8'h0, scan_block, gap_active, single_req, 6'h0};
      end else if (i_addr == ADDR_SCAN) begin
        o_rdata <= {25'h0, stop_source, 1'b0, scan_source};
      end else begin
        o_rdata <= 32'h0;
      end
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // Assertions
  sequence trig_s;
    o_meas_trig;
  endsequence

  holdoff_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    trig_s |=> !o_meas_trig [*8])
    else $error("trigger inside hold-off");
  drive_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    port_drive_out |-> source != SRC_AUX_ZERO)
    else $error("aux zero source while driving");
  reset_source_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(i_nrst) |-> source == SRC_INTERNAL)
    else $error("source not internal");
  edge_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    defaults && !(i_wr && i_addr == ADDR_EDGE) |=> $stable(edge_sel))
    else $error("defaults changed edge select");
  min_period_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    eff_period >= MIN_PERIOD_Q)
    else $error("period below minimum");
  pulse_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_meas_trig && port_drive_out |=> !o_aux_zero_out ##1 !o_aux_zero_out)
    else $error("no low output pulse");
  scan_block_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    scan_block |-> !o_meas_trig)
    else $error("trigger during scan delay");
  defaults_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    defaults && !megohm |=> sample_period == DEFAULT_PERIOD_Q)
    else $error("defaults period wrong");
  port_dir_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    port_drive_out |=> o_aux_zero_oe)
    else $error("port not driven");

endmodule

// ---- src/trig_pacer_pkg.sv ----
// Package with constants and types for the measure trigger and pacer block
package trig_pacer_pkg;

  // Register offsets
  localparam logic [3:0] ADDR_SOURCE = 4'h0;
  localparam logic [3:0] ADDR_EDGE = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_PORT = 4'h3;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_SCAN = 4'h6;

  // Field positions
  localparam int PORT_DRIVE_BIT = 0;
  localparam int AUTOSCAN_BIT = 1;
  localparam int NEW_REV_BIT = 2;
  localparam int MEGOHM_BIT = 3;
  localparam int CMD_DEFAULTS_BIT = 0;
  localparam int CMD_SINGLE_BIT = 1;
  localparam int SCAN_SRC_LSB = 0;
  localparam int STOP_SRC_LSB = 4;

  // Edge codes
  localparam logic rising_edge_code = 1'b0;
  localparam logic falling_edge_code = 1'b1;

  // Measure source selector
  typedef enum logic [2:0] {
    SRC_HOLD,
    SRC_SINGLE,
    SRC_SYSTEM,
    SRC_INTERNAL,
    SRC_AUX_ZERO,
    SRC_AUX_ONE,
    SRC_GP_PORT
  } src_t;

  // Timing: 0.25 us quanta rounded up to whole cycles, 3 cycles (0.3 us) at 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int QUANTUM_NS = 250;
  localparam int QUANTUM_CYCLES = (QUANTUM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [31:0] MIN_PERIOD_US = 32'h0000000a;
  localparam logic [31:0] MIN_PERIOD_Q = MIN_PERIOD_US * 32'h00000004;
  localparam logic [31:0] DEFAULT_PERIOD_Q = 32'h00000fa0;
  localparam logic [31:0] MEGOHM_PERIOD_Q = 32'h00005dc0;
  localparam logic [31:0] RESET_PERIOD_Q = DEFAULT_PERIOD_Q;
  localparam int HOLDOFF_CYCLES = 10 * (CLK_HZ / 1_000_000);
  localparam int PULSE_CYCLES = 2;

endpackage

// ---- testbench/trig_partner.sv ----
// External trigger sources and a listening voltmeter on aux port zero
`timescale 1ns/1ps
module trig_partner (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Requests from the bench
  input wire logic [2:0] i_toggle,
  // Aux port zero wire
  input wire logic i_port_level,
  input wire logic i_port_oe,
  // Source levels and received pulses
  output logic [2:0] o_lines,
  output logic [15:0] o_rx_pulses
);
  logic last_level;

  // Each request flips one line; requests come far apart, so levels hold many cycles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lines <= 3'h0;
    end else begin
      o_lines <= o_lines ^ i_toggle;
    end
  end

  // A low-going pulse on the driven port is taken as one measure trigger
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_level <= 1'b1;
      o_rx_pulses <= 16'h0;
    end else begin
      last_level <= i_port_oe ? i_port_level : 1'b1;
      if (i_port_oe && i_port_level && !last_level) begin
        o_rx_pulses <= o_rx_pulses + 16'h1;
      end
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the measure trigger and pacer block
`timescale 1ns/1ps
module tb;
  import trig_pacer_pkg::*;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] pv = 4'h0;
  logic [2:0] tg = 3'h0;
  logic [2:0] lines;
  logic [15:0] rx;
  logic [31:0] o_rdata;
  logic meas, gap_done, out0, oe0, aux0_wire;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int ntrig = 0;
  int tq[$];
  int p, e, b;

  always #50 i_clk = ~i_clk;
  assign aux0_wire = oe0 ? out0 : lines[0];

  trig_pacer DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_aux_zero(aux0_wire),
    .i_aux_one(lines[1]), .i_gp_port(lines[2]), .i_sys_trig(pv[0]),
    .i_scan_accept(pv[1]), .i_scan_delay_done(pv[2]), .i_pass_end(pv[3]),
    .o_meas_trig(meas), .o_pass_gap_done(gap_done), .o_aux_zero_out(out0),
    .o_aux_zero_oe(oe0));
  trig_partner partner (.i_clk(i_clk), .i_nrst(i_nrst), .i_toggle(tg),
    .i_port_level(aux0_wire), .i_port_oe(oe0), .o_lines(lines), .o_rx_pulses(rx));

  // Trigger log and run limit
  always @(posedge i_clk) begin
    cyc++;
    if (meas === 1'b1) begin
      ntrig++;
      tq.push_back(cyc);
    end
    if (cyc == LIMIT) begin
      fails++;
      print_verdict();
    end
  end

  // Expected pacer spacing in clock cycles
  function automatic int gap(int q);
    return (q <= 40 ? 40 : q) * QUANTUM_CYCLES;
  endfunction

  task automatic chk_val(string n, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic chk_cnt(string n, int exp, int got, int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdchk(string n, logic [3:0] a, logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk_val(n, exp, o_rdata);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic pulse(int k);
    @(posedge i_clk);
    pv[k] <= 1'b1;
    @(posedge i_clk);
    pv <= 4'h0;
  endtask
  task automatic flip(int k);
    @(posedge i_clk);
    tg[k] <= 1'b1;
    @(posedge i_clk);
    tg <= 3'h0;
  endtask
  task automatic wait_trig(int n);
    for (int k = 0; k < 5000 && ntrig < n; k++) @(posedge i_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    p = $urandom(32'h2106);
    wt(16);
    i_nrst <= 1'b1;
    p = 41 + $urandom % 50;
    wr(ADDR_PERIOD, 32'(p));
    rdchk("source reset", ADDR_SOURCE, 32'h3);
    rdchk("edge reset", ADDR_EDGE, 32'h0);
    rdchk("unmapped", 4'hf, 32'h0);
    rdchk("period", ADDR_PERIOD, 32'(p));
    wait_trig(3);
    chk_cnt("pacer gap", gap(p), tq[2] - tq[1], 0);
    p = $urandom % 41;
    wr(ADDR_PERIOD, 32'(p));
    wait_trig(ntrig + 3);
    chk_cnt("min gap", gap(p), tq[$] - tq[$-1], 0);
    wr(ADDR_PERIOD, 32'hffffffff);
    rdchk("period max", ADDR_PERIOD, 32'hffffffff);
    wr(ADDR_SOURCE, 32'h0);
    b = ntrig;
    wt(400);
    chk_cnt("hold", b, ntrig, 0);
    $display("test pacer done");
    for (int s = 4; s <= 6; s++) begin
      for (e = 0; e < 2; e++) begin
        wr(ADDR_SOURCE, 32'(s));
        wr(ADDR_EDGE, 32'(e));
        b = ntrig;
        flip(s - 4);
        wt(150);
        chk_cnt("rise trig", b + (e == 0), ntrig, 0);
        flip(s - 4);
        wt(150);
        chk_cnt("fall trig", b + 1, ntrig, 0);
      end
    end
    $display("test edges done");
    wr(ADDR_SOURCE, 32'h5);
    wr(ADDR_EDGE, 32'h0);
    wr(ADDR_PORT, 32'h5);
    wt(2);
    chk_val("oe on", 32'h1, {31'h0, oe0});
    wr(ADDR_SOURCE, 32'h4);
    rdchk("source refused", ADDR_SOURCE, 32'h5);
    wr(ADDR_SCAN, 32'h44);
    rdchk("scan refused", ADDR_SCAN, 32'h0);
    b = int'(rx);
    flip(1);
    wt(150);
    chk_cnt("rx pulses", b + 1, int'(rx), 0);
    wr(ADDR_PORT, 32'h4);
    wr(ADDR_SOURCE, 32'h4);
    wr(ADDR_PORT, 32'h5);
    rdchk("drive refused", ADDR_PORT, 32'h4);
    chk_val("oe off", 32'h0, {31'h0, oe0});
    $display("test port done");
    wr(ADDR_SOURCE, 32'h2);
    b = ntrig;
    pulse(0);
    wt(50);
    pulse(0);
    wt(150);
    chk_cnt("holdoff", b + 1, ntrig, 0);
    pulse(1);
    wt(5);
    pulse(0);
    wt(5);
    chk_cnt("scan block", b + 1, ntrig, 0);
    rdchk("status block", ADDR_STATUS, 32'h100);
    pulse(2);
    wt(5);
    pulse(0);
    wt(5);
    chk_cnt("unblock", b + 2, ntrig, 0);
    wr(ADDR_SOURCE, 32'h1);
    wr(ADDR_CMD, 32'h2);
    wt(120);
    chk_cnt("single", b + 3, ntrig, 0);
    $display("test sources done");
    wr(ADDR_SOURCE, 32'h0);
    wr(ADDR_PERIOD, 32'h64);
    for (e = 0; e < 2; e++) begin
      wr(ADDR_PORT, e ? 32'h4 : 32'h0);
      pulse(3);
      p = 0;
      while (gap_done !== 1'b1 && p < 2000) begin
        @(posedge i_clk);
        #1 p++;
      end
      chk_cnt("pass gap", e ? gap(100) : gap(0), p, 4);
    end
    $display("test pass gap done");
    wr(ADDR_EDGE, 32'h1);
    wr(ADDR_PORT, 32'hc);
    wr(ADDR_CMD, 32'h1);
    rdchk("megohm period", ADDR_PERIOD, 32'h00005dc0);
    rdchk("edge kept", ADDR_EDGE, 32'h1);
    wr(ADDR_PORT, 32'h4);
    wr(ADDR_CMD, 32'h1);
    rdchk("default period", ADDR_PERIOD, 32'h00000fa0);
    $display("test defaults done");
    print_verdict();
  end
endmodule
